// file: hw/port_cfg_pkg.sv
// Constants for the downstream port configuration register group.
// Assumes an 8-bit register address space reached by the serial port.
// Functional notes
// - Boost bits 6:4 set port 2 current
// - Boost bits 2:0 set port 1 current
// - Boost codes: nominal, -5, +10, +5 percent
// - Swap one exchanges D+ and D- pins
// - Swap bits 3,2,1 serve ports 3,2,1
// - Swap bits 7:4 and 0 reserved, ignored
// - Remap bits 7:4 place port 2; 0000 disables
// - Codes 1..3 give port 2 logical 1..3
// - Remap resets to identity mapping
// - Remap applies only while remap mode enabled
// - Hub reports port count; host numbers 1..N
// - Remap bits 3:0 place port 1, same codes
// - Reserved remap codes act as disabled
package port_cfg_pkg;
   // Register offsets
   localparam logic [7:0] BOOST_OFS  = 8'hF8;
   localparam logic [7:0] SWAP_OFS   = 8'hFA;
   localparam logic [7:0] REMAP_OFS  = 8'hFB;
   // Reset values
   localparam logic [7:0] BOOST_RST  = 8'h00;
   localparam logic [7:0] SWAP_RST   = 8'h00;
   localparam logic [7:0] REMAP_RST  = 8'h21;
   // Field positions
   localparam int BOOST_P1_LSB = 0;
   localparam int BOOST_P2_LSB = 4;
   localparam int SWAP_P1_BIT  = 1;
   localparam int SWAP_P2_BIT  = 2;
   localparam int SWAP_P3_BIT  = 3;
   localparam int REMAP_P1_LSB = 0;
   localparam int REMAP_P2_LSB = 4;
   // Writable bits; the rest read as zero
   localparam logic [7:0] BOOST_MASK = 8'h77;
   localparam logic [7:0] SWAP_MASK  = 8'h0E;
   // Remap codes
   localparam logic [3:0] MAP_OFF    = 4'h0;
   localparam logic [3:0] MAP_MAX    = 4'h3;
   localparam logic [1:0] NUM_PORTS  = 2'h3;
   // Boost decode, drive change in signed percent
   typedef enum logic [2:0] {
      BOOST_NOM  = 3'b000,
      BOOST_M5   = 3'b001,
      BOOST_P10  = 3'b010,
      BOOST_P5   = 3'b011,
      BOOST_P20  = 3'b100,
      BOOST_P15  = 3'b101,
      BOOST_P30  = 3'b110,
      BOOST_P25  = 3'b111
   } boost_code_t;
endpackage

// file: hw/boost_decode.sv
// Decoder from a three-bit boost code to a signed drive change in percent.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module boost_decode
   import port_cfg_pkg::*;
(
   input  wire logic [2:0]        code,    // Boost field
   output logic signed [6:0]      percent  // Drive change, percent
);
   // Codes beyond the four main steps follow the same ladder
   always_comb
   begin
      case (boost_code_t'(code))
         BOOST_NOM: percent = 7'sd0;
         BOOST_M5:  percent = -7'sd5;
         BOOST_P10: percent = 7'sd10;
         BOOST_P20: percent = 7'sd20;
         BOOST_P5:  percent = 7'sd5;
         BOOST_P15: percent = 7'sd15;
         BOOST_P30: percent = 7'sd30;
         default:   percent = 7'sd25;
      endcase
   end
endmodule // boost_decode

// file: hw/downstream_port_config_regs.sv
// Downstream port configuration registers: drive boost, pin swap, remap.
// Assumes a single-cycle register write/read strobe from the serial
// port engine, and a remap mode enable held in another register.
`timescale 1ns/10ps
module downstream_port_config_regs
   import port_cfg_pkg::*;
(
   input  wire logic        clk_sys,           // Core clock, 200 MHz
   input  wire logic        rst_n,             // Async reset, active low
   input  wire logic [7:0]  reg_addr,          // Register offset
   input  wire logic [7:0]  reg_wdata,         // Write data
   input  wire logic        reg_wr,            // Write strobe
   input  wire logic        reg_rd,            // Read strobe
   output logic      [7:0]  reg_rdata,         // Read data
   output logic             reg_rvalid,        // Read data valid
   input  wire logic        remap_mode_enable, // Remap mode on
   input  wire logic [3:0]  port3_remap_code,  // Port 3 remap field
   output logic      [2:0]  port1_current_boost, // Port 1 boost code
   output logic      [2:0]  port2_current_boost, // Port 2 boost code
   output logic signed [6:0] port1_boost_pct,  // Port 1 drive change
   output logic signed [6:0] port2_boost_pct,  // Port 2 drive change
   output logic      [3:1]  port_dp_dm_swap,   // Per-port D+/D- swap
   output logic      [1:0]  port1_logical,     // 0 = disabled
   output logic      [1:0]  port2_logical,     // 0 = disabled
   output logic      [1:0]  port3_logical,     // 0 = disabled
   output logic      [1:0]  port_count         // Ports reported to host
);
   typedef struct packed {
      logic [7:0]        boost;
      logic [7:0]        swap;
      logic [7:0]        remap;
      logic [7:0]        rdata;
      logic              rvalid;
      logic signed [6:0] pct1;
      logic signed [6:0] pct2;
      logic [1:0]        log1;
      logic [1:0]        log2;
      logic [1:0]        log3;
      logic [1:0]        count;
   } state_t;

   localparam state_t STATE_RST = '{
      boost: BOOST_RST, swap: SWAP_RST, remap: REMAP_RST,
      rdata: 8'h00, rvalid: 1'b0, pct1: 7'sd0, pct2: 7'sd0,
      log1: 2'h1, log2: 2'h2, log3: 2'h3, count: NUM_PORTS};

   state_t state_ff;
   state_t nxt_state;
   logic signed [6:0] nxt_pct1;
   logic signed [6:0] nxt_pct2;

   // Reserved codes fold into disabled
   function automatic logic [1:0] map_code(input logic [3:0] code);
      if (code > MAP_MAX)
         map_code = 2'h0;
      else
         map_code = code[1:0];
   endfunction

   function automatic logic [1:0] is_on(input logic [1:0] lp);
      is_on = {1'b0, lp != 2'h0};
   endfunction

   // Decoders look at the next boost value so outputs stay aligned
   boost_decode u_dec1 (
      .code    (nxt_state.boost[BOOST_P1_LSB +: 3]),
      .percent (nxt_pct1)
   );
   boost_decode u_dec2 (
      .code    (nxt_state.boost[BOOST_P2_LSB +: 3]),
      .percent (nxt_pct2)
   );

   // Register writes, reads and derived port settings
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.rvalid = reg_rd;
      if (reg_wr)
      begin
         if (reg_addr == BOOST_OFS)
            nxt_state.boost = reg_wdata & BOOST_MASK;
         else if (reg_addr == SWAP_OFS)
            nxt_state.swap = reg_wdata & SWAP_MASK;
         else if (reg_addr == REMAP_OFS)
            nxt_state.remap = reg_wdata;
      end
      // Unmapped offsets read zero
      if (reg_rd)
      begin
         if (reg_addr == BOOST_OFS)
            nxt_state.rdata = state_ff.boost;
         else if (reg_addr == SWAP_OFS)
            nxt_state.rdata = state_ff.swap;
         else if (reg_addr == REMAP_OFS)
            nxt_state.rdata = state_ff.remap;
         else
            nxt_state.rdata = 8'h00;
      end
      nxt_state.pct1 = nxt_pct1;
      nxt_state.pct2 = nxt_pct2;
      // Outside remap mode every port keeps its own number
      if (remap_mode_enable)
      begin
         nxt_state.log1 = map_code(nxt_state.remap[REMAP_P1_LSB +: 4]);
         nxt_state.log2 = map_code(nxt_state.remap[REMAP_P2_LSB +: 4]);
         nxt_state.log3 = map_code(port3_remap_code);
      end
      else
      begin
         nxt_state.log1 = 2'h1;
         nxt_state.log2 = 2'h2;
         nxt_state.log3 = 2'h3;
      end
      // Only a count is reported; a gapped map is software's fault
      nxt_state.count = is_on(nxt_state.log1) + is_on(nxt_state.log2)
                      + is_on(nxt_state.log3);
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         state_ff <= STATE_RST;
      else
         state_ff <= nxt_state;
   end

   // All outputs come straight from the state register
   assign reg_rdata           = state_ff.rdata;
   assign reg_rvalid          = state_ff.rvalid;
   assign port1_current_boost = state_ff.boost[BOOST_P1_LSB +: 3];
   assign port2_current_boost = state_ff.boost[BOOST_P2_LSB +: 3];
   assign port1_boost_pct     = state_ff.pct1;
   assign port2_boost_pct     = state_ff.pct2;
   // One means D+ on the DM pin and D- on the DP pin
   assign port_dp_dm_swap     = state_ff.swap[SWAP_P3_BIT:SWAP_P1_BIT];
   assign port1_logical       = state_ff.log1;
   assign port2_logical       = state_ff.log2;
   assign port3_logical       = state_ff.log3;
   assign port_count          = state_ff.count;
endmodule // downstream_port_config_regs

// file: tb/port_cfg_monitor.sv
// Checker for the port configuration registers, bound to the top module.
// Assumes one clock domain and the one-cycle strobe bus.
`timescale 1ns/10ps
module port_cfg_monitor
   import port_cfg_pkg::*;
(
   input wire logic        clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid,
   input wire logic        remap_mode_enable,
   input wire logic [7:0]  reg_addr, reg_wdata,
   input wire logic [2:0]  port1_current_boost, port2_current_boost,
   input wire logic signed [6:0] port1_boost_pct,
   input wire logic [3:1]  port_dp_dm_swap,
   input wire logic [1:0]  port1_logical, port2_logical, port3_logical,
   input wire logic [1:0]  port_count
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Writes are taken at one edge and show on outputs the next cycle
   sequence boost_wr; reg_wr && reg_addr == BOOST_OFS; endsequence
   sequence map_wr;
      remap_mode_enable && reg_wr && reg_addr == REMAP_OFS;
   endsequence
   a_read_answer:
      assert property (reg_rd |=> reg_rvalid) else $error("no read data");
   a_boost_port1:
      assert property (boost_wr |=> port1_current_boost ==
         $past(reg_wdata[2:0])) else $error("port 1 boost wrong");
   a_boost_port2:
      assert property (boost_wr |=> port2_current_boost ==
         $past(reg_wdata[6:4])) else $error("port 2 boost wrong");
   a_boost_decode:
      assert property (port1_current_boost == 3'h4 |->
         port1_boost_pct == 7'sh14) else $error("boost decode wrong");
   a_swap_bits:
      assert property (reg_wr && reg_addr == SWAP_OFS |=> port_dp_dm_swap
         == $past(reg_wdata[3:1])) else $error("swap bits wrong");
   a_mode_off:
      assert property (!remap_mode_enable |=> port1_logical == 2'h1 &&
         port2_logical == 2'h2 && port3_logical == 2'h3)
         else $error("default numbering lost");
   a_map_port2:
      assert property (map_wr |=> port2_logical == ($past(reg_wdata[7:4])
         > MAP_MAX ? 2'h0 : $past(reg_wdata[5:4]))) else $error("map 2");
   a_map_port1:
      assert property (map_wr |=> port1_logical == ($past(reg_wdata[3:0])
         > MAP_MAX ? 2'h0 : $past(reg_wdata[1:0]))) else $error("map 1");
   a_port_count:
      assert property (port_count == (port1_logical != 2'h0) +
         (port2_logical != 2'h0) + (port3_logical != 2'h0))
         else $error("port count wrong");
endmodule // port_cfg_monitor
bind downstream_port_config_regs port_cfg_monitor i_port_cfg_monitor (.*);

// file: tb/cfg_host_model.sv
// System processor model issuing register writes and reads.
// Assumes read data arrives exactly one cycle after the strobe edge.
`timescale 1ns/10ps
module cfg_host_model
(
   input  wire logic       clk_sys,   // Core clock
   output logic      [7:0] reg_addr,  // Register offset
   output logic      [7:0] reg_wdata, // Write data
   output logic            reg_wr,    // Write strobe
   output logic            reg_rd,    // Read strobe
   input  wire logic [7:0] reg_rdata, // Read data
   input  wire logic       reg_rvalid // Read data valid
);
   initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
   // Released lines are inverted so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk_sys);
      {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
      @(posedge clk_sys);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk_sys);
      {reg_addr, reg_rd} <= {~a, 1'b0};
      #1;
      ok = reg_rvalid === 1'b1;
      d = reg_rdata;
   endtask
endmodule // cfg_host_model

// file: tb/downstream_port_config_regs_tb.sv
// Self-checking bench for the port configuration registers.
// Assumes the host model drives the bus and the checker is bound in.
`timescale 1ns/10ps
module downstream_port_config_regs_tb;
   import port_cfg_pkg::*;
   logic clk_sys = 1'b0, rst_n = 1'b0, remap_mode_enable = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid, ok;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [3:0] port3_remap_code = 4'h3;
   logic [2:0] port1_current_boost, port2_current_boost;
   logic signed [6:0] port1_boost_pct, port2_boost_pct;
   logic [3:1] port_dp_dm_swap;
   logic [1:0] port1_logical, port2_logical, port3_logical, port_count;
   logic [6:0] tab [8] = '{7'h00, 7'h7B, 7'h0A, 7'h05, 7'h14, 7'h0F,
                           7'h1E, 7'h19};
   int miscompares = 0, comparisons = 0;
   downstream_port_config_regs i_downstream_port_config_regs (.*);
   cfg_host_model i_cfg_host_model (.*);
   initial forever #2.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      i_cfg_host_model.rd(a, d, ok);
      chk({7'h00, ok}, 8'h01);
      chk(d, exp);
   endtask
   task automatic t_boost();
      rdchk(REMAP_OFS, 8'h21);
      for (int c = 0; c < 8; c++)
      begin
         i_cfg_host_model.wr(BOOST_OFS, {1'b1, 3'(7 - c), 1'b1, 3'(c)});
         chk({5'h00, port1_current_boost}, 8'(c));
         chk({5'h00, port2_current_boost}, 8'(7 - c));
         chk({1'b0, port1_boost_pct}, {1'b0, tab[c]});
         chk({1'b0, port2_boost_pct}, {1'b0, tab[7 - c]});
      end
      rdchk(BOOST_OFS, 8'h07);
      $display("boost test done");
   endtask
   task automatic t_swap();
      i_cfg_host_model.wr(SWAP_OFS, 8'hF5);
      chk({5'h00, port_dp_dm_swap}, 8'h02);
      i_cfg_host_model.wr(SWAP_OFS, 8'h0A);
      i_cfg_host_model.wr(8'h00, 8'hFF);
      chk({5'h00, port_dp_dm_swap}, 8'h05);
      rdchk(SWAP_OFS, 8'h0A);
      rdchk(8'h00, 8'h00);
      $display("swap test done");
   endtask
   task automatic t_remap();
      @(posedge clk_sys);
      remap_mode_enable <= 1'b1;
      i_cfg_host_model.wr(REMAP_OFS, 8'h12);
      chk({port1_logical, port2_logical, port3_logical, port_count},
          8'h9F);
      @(posedge clk_sys);
      port3_remap_code <= 4'h1;
      i_cfg_host_model.wr(REMAP_OFS, 8'h40);
      chk({port1_logical, port2_logical, port3_logical, port_count},
          8'h05);
      rdchk(REMAP_OFS, 8'h40);
      @(posedge clk_sys);
      remap_mode_enable <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk({port1_logical, port2_logical, port3_logical, port_count},
          8'h6F);
      $display("remap test done");
   endtask
   task automatic summarize();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Reset for six cycles, then each scenario in turn
   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_boost();
      t_swap();
      t_remap();
      summarize();
   end
endmodule // downstream_port_config_regs_tb
